// ### bench/sng_can_far_side.sv
/* Far side of the CAN link: traction controller reporting drive speed.
   Assumes the bench sets link and speed controls just after a clock edge. */
`timescale 1ns/1ps
module sng_can_far_side (
    input  wire logic        clk,
    input  wire logic        link_up,
    input  wire logic        speed_ok,
    input  wire logic [10:0] traction_speed,
    output logic             can_connected,
    output logic             drive_speed_valid,
    output logic [10:0]      drive_speed
);
    // Speed only reaches the steering side over a live link
    // Without a valid frame the lines show the inverse, so stale data never looks good
    always_ff @(posedge clk) begin
        can_connected     <= link_up;
        drive_speed_valid <= link_up & speed_ok;
        drive_speed       <= (link_up & speed_ok) ? traction_speed : ~traction_speed;
    end
endmodule

// ### bench/sng_steer_shaping_asserts.sv
/* Checker of shaping outputs against their input causes.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
module sng_steer_shaping_asserts (
    input wire logic               clk,
    input wire logic               reset,
    input wire sng_pkg::sng_mode_t mode,
    input wire logic [7:0]         remote_node_select,
    input wire logic [7:0]         handset_node,
    input wire logic [1:0]         local_processor_select,
    input wire logic               handset_to_main,
    input wire logic               handset_to_slave,
    input wire logic               motor_slow,
    input wire logic [3:0]         min_torque_level,
    input wire logic [7:0]         min_torque,
    input wire logic [3:0]         position_gain_coarse,
    input wire logic [3:0]         position_gain_fine,
    input wire logic [7:0]         position_gain,
    input wire logic               position_gain_active,
    input wire logic signed [11:0] commanded_pos,
    input wire logic signed [11:0] steady_pos,
    input wire logic [11:0]        steering_error,
    input wire logic               encoder_toggle_feedback,
    input wire logic               centering_option,
    input wire logic               centering_enable,
    input wire logic [7:0]         turn_scale,
    input wire logic [10:0]        max_angle
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    logic signed [11:0] diff;
    logic        [11:0] err_abs;
    // Error magnitude, wrapping at the port width
    assign diff    = commanded_pos - steady_pos;
    assign err_abs = diff[11] ? 12'(-diff) : 12'(diff);

    property p_node; 1 |=> handset_node == $past(remote_node_select); endproperty
    a_node: assert property (p_node)
        else $error("hand-set node differs from selection");
    property p_route; 1 |=> handset_to_main == ($past(local_processor_select) == 2'h0)
        && handset_to_slave == ($past(local_processor_select) == 2'h1); endproperty
    a_route: assert property (p_route)
        else $error("hand-set routing flags wrong");
    property p_torque; min_torque_level <= 4'h9 |=>
        min_torque == ($past(motor_slow) ? 8'($past(min_torque_level)) * 8'h0a : 8'h00); endproperty
    a_torque: assert property (p_torque)
        else $error("creep torque wrong");
    property p_gain; mode != sng_pkg::SNG_OPEN_LOOP && position_gain_coarse <= 4'h9 && position_gain_fine <= 4'h9
        |=> position_gain_active && position_gain == 8'($past(position_gain_coarse)) * 8'h0a
        + 8'($past(position_gain_fine)); endproperty
    a_gain: assert property (p_gain)
        else $error("combined gain wrong");
    property p_gain_off; mode == sng_pkg::SNG_OPEN_LOOP |=> !position_gain_active && position_gain == 8'h00;
    endproperty
    a_gain_off: assert property (p_gain_off)
        else $error("gain active in open loop");
    property p_err; 1 |=> steering_error == $past(err_abs); endproperty
    a_err: assert property (p_err)
        else $error("steering error wrong");
    property p_center; 1 |=> centering_enable == ($past(encoder_toggle_feedback) && $past(centering_option));
    endproperty
    a_center: assert property (p_center)
        else $error("centering enable wrong");
    property p_scale_off; (mode != sng_pkg::SNG_OPEN_LOOP) [*3] |-> turn_scale == 8'h00; endproperty
    a_scale_off: assert property (p_scale_off)
        else $error("turn scale outside open loop");
    property p_angle_open; (mode != sng_pkg::SNG_CLOSED_LOOP) [*4] |-> max_angle == 11'h384; endproperty
    a_angle_open: assert property (p_angle_open)
        else $error("angle limited outside closed loop");
endmodule

// ### bench/sng_steer_shaping_test.sv
/* Random and corner-case bench of the steering shaping block.
   Assumes the package is compiled first and the far side registers speed. */
`timescale 1ns/1ps
module sng_steer_shaping_test;
    logic               clk, reset, wheel_fast, motor_slow, encoder_toggle_feedback, centering_option;
    logic               link_up, speed_ok, can_connected, drive_speed_valid;
    sng_pkg::sng_mode_t mode;
    logic [10:0]        drive_speed, traction_speed, max_angle;
    logic [3:0]         speed_numb_full_level, speed_numb_start_level, fast_gain_level, slow_gain_level;
    logic [3:0]         min_torque_level, position_gain_coarse, position_gain_fine, auto_request_kind;
    logic [3:0]         error_numbness_angle, error_numbness_speed_floor;
    logic signed [11:0] commanded_pos, steady_pos;
    logic [15:0]        saturation_frequency, extra_frequency_headroom;
    logic [7:0]         remote_node_select, turn_scale, min_torque, position_gain, handset_node;
    logic [1:0]         local_processor_select;
    logic [11:0]        steering_error;
    logic [16:0]        motor_freq_limit;
    logic               position_gain_active, handset_to_main, handset_to_slave, centering_enable;
    int                 seed = 44;
    int                 fail_count = 0;
    int                 samples_checked = 0;

    sng_steer_shaping DUT (.*);
    sng_can_far_side far_side (.*);

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ************************************************************
    // Expectation helpers
    // ************************************************************
    function automatic int lv(input logic [3:0] l); return (l > 4'h9) ? 9 : int'(l); endfunction
    function automatic int r(input int n); return ($random(seed) & 32'h7fffffff) % n; endfunction
    function automatic int spd();
        if (!(link_up && speed_ok)) return 0;
        return (int'(traction_speed) > 1000) ? 1000 : int'(traction_speed);
    endfunction
    function automatic int ang();
        return (lv(error_numbness_angle) == 9) ? 600 : 50 + 60 * lv(error_numbness_angle);
    endfunction
    function automatic int errv();
        int e;
        e = int'(commanded_pos) - int'(steady_pos);
        return (e < 0) ? -e : e;
    endfunction
    function automatic int exp_angle();
        int f, s;
        f = (lv(speed_numb_full_level) == 9) ? 100 : 730 - 70 * lv(speed_numb_full_level);
        s = (lv(speed_numb_start_level) == 9) ? 1000 : 10 + 110 * lv(speed_numb_start_level);
        if (mode != sng_pkg::SNG_CLOSED_LOOP || spd() <= s) return 900;
        return 900 * (1000 - (1000 - f) * (spd() - s) / (1000 - s)) / 1000;
    endfunction
    function automatic int exp_scale();
        int g, n;
        g = lv(wheel_fast ? fast_gain_level : slow_gain_level);
        n = lv(wheel_fast ? speed_numb_full_level : speed_numb_start_level);
        if (mode != sng_pkg::SNG_OPEN_LOOP) return 0;
        return (g + 1) * 10 * (1000 - n * 100 * spd() / 1000) / 1000;
    endfunction
    function automatic int exp_freq();
        int a, fl, e, pm;
        a  = ang();
        e  = errv();
        fl = (lv(error_numbness_speed_floor) == 9) ? 1000 : 400 + 66 * lv(error_numbness_speed_floor);
        if (mode == sng_pkg::SNG_OPEN_LOOP || e >= a) pm = 1000;
        else if (5 * e <= 2 * a) pm = fl;
        else pm = fl + (1000 - fl) * (5 * e - 2 * a) / (3 * a);
        return (int'(saturation_frequency) + int'(extra_frequency_headroom)) * pm / 1000;
    endfunction

    // ************************************************************
    // Compare, stimulus and verdict
    // ************************************************************
    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Let the far side and both pipeline stages settle before comparing
    task automatic check_all();
        repeat (5) @(posedge clk);
        #1;
        chk(17'(max_angle), 17'(exp_angle()));
        chk(17'(turn_scale), 17'(exp_scale()));
        chk(17'(min_torque), 17'(motor_slow ? 10 * lv(min_torque_level) : 0));
        chk(17'(position_gain), 17'((mode == sng_pkg::SNG_OPEN_LOOP) ? 0
            : 10 * lv(position_gain_coarse) + lv(position_gain_fine)));
        chk(17'(position_gain_active), 17'(mode != sng_pkg::SNG_OPEN_LOOP));
        chk(17'(steering_error), 17'(errv()));
        chk(motor_freq_limit, 17'(exp_freq()));
        chk(17'(handset_node), 17'(remote_node_select));
        chk(17'({handset_to_main, handset_to_slave}),
            17'({local_processor_select == 2'h0, local_processor_select == 2'h1}));
        chk(17'(centering_enable), 17'(encoder_toggle_feedback & centering_option));
    endtask
    // Speeds of 0 or full only, and errors off the ramp, keep results exact
    task automatic shuffle();
        int off;
        mode = sng_pkg::sng_mode_t'(r(3));
        {wheel_fast, motor_slow, encoder_toggle_feedback, centering_option} = 4'(r(16));
        {link_up, speed_ok} = 2'(r(4) | 1);
        traction_speed = r(2) ? 11'h3e8 : 11'h000;
        {speed_numb_full_level, speed_numb_start_level, fast_gain_level, slow_gain_level,
         min_torque_level, position_gain_coarse, position_gain_fine, auto_request_kind} = $random(seed);
        {error_numbness_angle, error_numbness_speed_floor, remote_node_select,
         local_processor_select} = 18'($random(seed));
        saturation_frequency = 16'(1000 * r(41));
        extra_frequency_headroom = 16'(1000 * r(25));
        steady_pos = 12'(r(1001) - 500);
        off = r(2) ? r(2 * ang() / 5 + 1) : ang() + r(200);
        commanded_pos = 12'(int'(steady_pos) + (r(2) ? off : -off));
    endtask
    task automatic wrap_up();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        reset = 1'b1;
        shuffle();
        repeat (2) @(posedge clk);
        #1;
        reset = 1'b0;
        // Closed loop at full, part, over-range and invalid speed, error on both sides of the ramp
        mode = sng_pkg::SNG_CLOSED_LOOP;
        {link_up, speed_ok, traction_speed} = {2'h3, 11'h3e8};
        {speed_numb_full_level, speed_numb_start_level} = 8'h00;
        {error_numbness_angle, error_numbness_speed_floor} = 8'h00;
        {saturation_frequency, extra_frequency_headroom} = {16'h03e8, 16'h0000};
        {commanded_pos, steady_pos} = {12'h023, 12'h000};
        check_all();
        commanded_pos = 12'h00a;
        check_all();
        commanded_pos = 12'hfce;
        check_all();
        {speed_numb_full_level, speed_numb_start_level, traction_speed} = {8'h14, 11'h2d5};
        check_all();
        traction_speed = 11'h7ff;
        check_all();
        speed_ok = 1'b0;
        check_all();
        // Open loop, slow wheel at half speed, then fast wheel at full speed
        mode = sng_pkg::SNG_OPEN_LOOP;
        {wheel_fast, slow_gain_level, speed_ok, traction_speed} = {1'b0, 4'h3, 1'b1, 11'h1f4};
        check_all();
        {wheel_fast, fast_gain_level, speed_numb_full_level, traction_speed} = {1'b1, 8'hf9, 11'h3e8};
        check_all();
        link_up = 1'b0;
        check_all();
        repeat (300) begin
            shuffle();
            check_all();
        end
        // Reset again in mid-run
        reset = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk(17'(max_angle), 17'h00384);
        chk(17'({handset_to_main, handset_to_slave}), 17'h00002);
        reset = 1'b0;
        check_all();
        wrap_up();
    end
endmodule

bind sng_steer_shaping sng_steer_shaping_asserts u_asserts (.*);

// ### pkg/sng_pkg.sv
/*
 * Shared constants of the steering numbness and gain select block: setting
 * levels, per-level weights, limits, mode encoding and hand-set routing codes.
 * Assumes all percentages are carried in permille and all angles in tenths of
 * a degree, so that fractional weights stay exact in integer logic.
 */
// Contract
// - Closed loop: full-speed angle 73% minus 7%/level
// - Reduction starts at 1% plus 11%/level speed
// - Fast-turn numbness attenuates scaling with drive speed
// - Slow-turn numbness attenuates scaling with drive speed
// - Drive speed comes over CAN; needs link
// - Fast-turn gain level sets fast scaling
// - Slow-turn gain level sets slow scaling
// - Minimum torque by level while motor slow
// - Proportional term in closed loop and centering
// - Coarse and fine combine into one gain
// - Error is command minus last steady position
// - Error above numbness angle: no speed clamp
// - Error below 40% of angle: full clamp
// - Numbness angle 5 degrees plus 6/level, 60 max
// - Clamp floor 40% plus 6.6%/level, 100 max
// - Hand-set forwarded to selected remote node
// - Local select 0 main, 1 slave processor
// - Request kind ineffective; centering option on encoder
package sng_pkg;

    // ************************************************************
    // Levels and scales
    // ************************************************************
    localparam logic [3:0]  LVL_MAX        = 4'h9;
    localparam logic [10:0] PM_FULL        = 11'h3e8;  // 100.0 %
    localparam logic [10:0] ABS_MAX_ANGLE  = 11'h384;  // 90.0 degrees

    // ************************************************************
    // Speed-dependent angle limit, closed loop
    // ************************************************************
    localparam logic [10:0] ANG_FULL_BASE  = 11'h2da;  // 73.0 %
    localparam logic [10:0] ANG_FULL_STEP  = 11'h046;  // 7.0 %
    localparam logic [10:0] ANG_FULL_TOP   = 11'h064;  // 10.0 %
    localparam logic [10:0] START_BASE     = 11'h00a;  // 1.0 %
    localparam logic [10:0] START_STEP     = 11'h06e;  // 11.0 %
    localparam logic [10:0] START_TOP      = 11'h3e8;  // 100.0 %

    // ************************************************************
    // Error numbness
    // ************************************************************
    localparam logic [10:0] ERR_ANG_BASE   = 11'h032;  // 5.0 degrees
    localparam logic [10:0] ERR_ANG_STEP   = 11'h03c;  // 6.0 degrees
    localparam logic [10:0] ERR_ANG_TOP    = 11'h258;  // 60.0 degrees
    localparam logic [10:0] FLOOR_BASE     = 11'h190;  // 40.0 %
    localparam logic [10:0] FLOOR_STEP     = 11'h042;  // 6.6 %
    localparam logic [10:0] FLOOR_TOP      = 11'h3e8;  // 100.0 %
    localparam logic [10:0] ERR_LOW_PM     = 11'h190;  // 40 % of numbness angle

    // ************************************************************
    // Open-loop scaling, torque and gain
    // ************************************************************
    localparam logic [7:0]  GAIN_STEP      = 8'h0a;    // scale units per gain level
    localparam logic [10:0] ATT_STEP_PM    = 11'h064;  // attenuation per level at full speed
    localparam logic [7:0]  TORQUE_STEP    = 8'h0a;    // torque units per level
    localparam logic [7:0]  FINE_PER_COARSE = 8'h0a;   // fine steps in one coarse step

    // ************************************************************
    // Modes and routing
    // ************************************************************
    typedef enum logic [1:0] {
        SNG_OPEN_LOOP,
        SNG_CLOSED_LOOP,
        SNG_AUTO_CENTER
    } sng_mode_t;

    localparam logic [1:0]  LOCAL_MAIN     = 2'h0;
    localparam logic [1:0]  LOCAL_SLAVE    = 2'h1;

endpackage

// ### rtl/sng_level_map.sv
/*
 * Turns a ten-step setting level into a value by a base and a per-step weight,
 * with the top level pinned to its documented end value. Output is registered.
 * Assumes the level comes from logic on the same clock.
 */
`timescale 1ns/1ps
module sng_level_map #(
    parameter logic [10:0] BASE    = 11'h000,
    parameter logic [10:0] STEP    = 11'h001,
    parameter logic [10:0] TOP     = 11'h009,
    parameter bit          DESCEND = 1'b0
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [3:0]  level,
    output logic      [10:0] value
);

    logic [10:0] next_value;
    logic [14:0] prod;

    // ************************************************************
    // Interpolation
    // ************************************************************
    // Top level pinned so rounding of the weight never misses the end value
    always_comb begin
        prod = STEP * level;
        if (level >= sng_pkg::LVL_MAX) begin
            next_value = TOP;
        end else if (DESCEND) begin
            next_value = BASE - prod[10:0];
        end else begin
            next_value = BASE + prod[10:0];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            value <= BASE;
        end else begin
            value <= next_value;
        end
    end

endmodule

// ### rtl/sng_steer_shaping.sv
/*
 * Steering numbness and gain select: turns setting levels into the angle
 * limit, open-loop turn scaling, creep torque, proportional gain and motor
 * speed clamp, and routes the service hand-set.
 * Assumes every input comes from logic on clk; drive speed is already decoded
 * from the CAN link in permille of full drive speed.
 */
`timescale 1ns/1ps
module sng_steer_shaping (
    input  wire logic                clk,
    input  wire logic                reset,
    input  wire sng_pkg::sng_mode_t  mode,
    input  wire logic                can_connected,
    input  wire logic                drive_speed_valid,
    input  wire logic [10:0]         drive_speed,
    input  wire logic [3:0]          speed_numb_full_level,
    input  wire logic [3:0]          speed_numb_start_level,
    input  wire logic                wheel_fast,
    input  wire logic [3:0]          fast_gain_level,
    input  wire logic [3:0]          slow_gain_level,
    input  wire logic                motor_slow,
    input  wire logic [3:0]          min_torque_level,
    input  wire logic [3:0]          position_gain_coarse,
    input  wire logic [3:0]          position_gain_fine,
    input  wire logic signed [11:0]  commanded_pos,
    input  wire logic signed [11:0]  steady_pos,
    input  wire logic [3:0]          error_numbness_angle,
    input  wire logic [3:0]          error_numbness_speed_floor,
    input  wire logic [15:0]         saturation_frequency,
    input  wire logic [15:0]         extra_frequency_headroom,
    input  wire logic [7:0]          remote_node_select,
    input  wire logic [1:0]          local_processor_select,
    input  wire logic [3:0]          auto_request_kind,
    input  wire logic                encoder_toggle_feedback,
    input  wire logic                centering_option,
    output logic [10:0]              max_angle,
    output logic [7:0]               turn_scale,
    output logic [7:0]               min_torque,
    output logic [7:0]               position_gain,
    output logic                     position_gain_active,
    output logic [11:0]              steering_error,
    output logic [16:0]              motor_freq_limit,
    output logic [7:0]               handset_node,
    output logic                     handset_to_main,
    output logic                     handset_to_slave,
    output logic                     centering_enable
);

    // ************************************************************
    // Helpers
    // ************************************************************
    // Saturate a level to the documented range
    function automatic logic [3:0] sat_level(input logic [3:0] lvl);
        sat_level = (lvl > sng_pkg::LVL_MAX) ? sng_pkg::LVL_MAX : lvl;
    endfunction

    // Scale a value by a permille factor
    function automatic logic [31:0] mul_pm(input logic [31:0] val, input logic [10:0] pm);
        mul_pm = (val * {21'h0, pm}) / {21'h0, sng_pkg::PM_FULL};
    endfunction

    // ************************************************************
    // Level maps
    // ************************************************************
    logic [10:0] ang_full_pm;
    logic [10:0] start_pm;
    logic [10:0] err_ang;
    logic [10:0] floor_pm;

    sng_level_map #(
        .BASE    (sng_pkg::ANG_FULL_BASE),
        .STEP    (sng_pkg::ANG_FULL_STEP),
        .TOP     (sng_pkg::ANG_FULL_TOP),
        .DESCEND (1'b1)
    ) u_ang_full (
        .clk     (clk),
        .reset   (reset),
        .level   (sat_level(speed_numb_full_level)),
        .value   (ang_full_pm)
    );

    sng_level_map #(
        .BASE    (sng_pkg::START_BASE),
        .STEP    (sng_pkg::START_STEP),
        .TOP     (sng_pkg::START_TOP),
        .DESCEND (1'b0)
    ) u_start (
        .clk     (clk),
        .reset   (reset),
        .level   (sat_level(speed_numb_start_level)),
        .value   (start_pm)
    );

    sng_level_map #(
        .BASE    (sng_pkg::ERR_ANG_BASE),
        .STEP    (sng_pkg::ERR_ANG_STEP),
        .TOP     (sng_pkg::ERR_ANG_TOP),
        .DESCEND (1'b0)
    ) u_err_ang (
        .clk     (clk),
        .reset   (reset),
        .level   (sat_level(error_numbness_angle)),
        .value   (err_ang)
    );

    sng_level_map #(
        .BASE    (sng_pkg::FLOOR_BASE),
        .STEP    (sng_pkg::FLOOR_STEP),
        .TOP     (sng_pkg::FLOOR_TOP),
        .DESCEND (1'b0)
    ) u_floor (
        .clk     (clk),
        .reset   (reset),
        .level   (sat_level(error_numbness_speed_floor)),
        .value   (floor_pm)
    );

    // ************************************************************
    // Drive speed
    // ************************************************************
    // Without the link the speed is taken as standstill, so no speed numbness acts
    logic [10:0] speed;
    always_comb begin
        if (!can_connected || !drive_speed_valid) begin
            speed = 11'h000;
        end else if (drive_speed > sng_pkg::PM_FULL) begin
            speed = sng_pkg::PM_FULL;
        end else begin
            speed = drive_speed;
        end
    end

    // ************************************************************
    // Next values
    // ************************************************************
    logic [10:0] next_max_angle;
    logic [7:0]  next_turn_scale;
    logic [7:0]  next_min_torque;
    logic [7:0]  next_position_gain;
    logic        next_position_gain_active;
    logic [11:0] next_steering_error;
    logic [16:0] next_motor_freq_limit;
    logic [7:0]  next_handset_node;
    logic        next_handset_to_main;
    logic        next_handset_to_slave;
    logic        next_centering_enable;

    always_comb begin
        logic [31:0] red;
        logic [31:0] att;
        logic [31:0] base;
        logic [31:0] pm;
        logic [31:0] full;
        logic [31:0] lo;
        logic [11:0] diff;
        logic [3:0]  gain_lvl;
        logic [3:0]  numb_lvl;
        logic        closed;
        red      = 32'h0;
        att      = 32'h0;
        base     = 32'h0;
        pm       = 32'h0;
        full     = 32'h0;
        lo       = 32'h0;
        diff     = 12'h000;
        gain_lvl = 4'h0;
        numb_lvl = 4'h0;
        closed   = (mode == sng_pkg::SNG_CLOSED_LOOP) || (mode == sng_pkg::SNG_AUTO_CENTER);

        // Angle limit shrinks linearly from the start speed to full speed
        if (mode != sng_pkg::SNG_CLOSED_LOOP || speed <= start_pm) begin
            next_max_angle = sng_pkg::ABS_MAX_ANGLE;
        end else begin
            red = ({21'h0, sng_pkg::PM_FULL - ang_full_pm} * {21'h0, speed - start_pm})
                  / {21'h0, sng_pkg::PM_FULL - start_pm};
            next_max_angle = 11'(mul_pm({21'h0, sng_pkg::ABS_MAX_ANGLE},
                                        sng_pkg::PM_FULL - red[10:0]));
        end

        // Open-loop scaling: gain picks the slope, numbness trims it with speed
        if (wheel_fast) begin
            gain_lvl = sat_level(fast_gain_level);
            numb_lvl = sat_level(speed_numb_full_level);
        end else begin
            gain_lvl = sat_level(slow_gain_level);
            numb_lvl = sat_level(speed_numb_start_level);
        end
        base = ({28'h0, gain_lvl} + 32'h1) * {24'h0, sng_pkg::GAIN_STEP};
        att  = mul_pm({28'h0, numb_lvl} * {21'h0, sng_pkg::ATT_STEP_PM}, speed);
        if (mode == sng_pkg::SNG_OPEN_LOOP) begin
            next_turn_scale = 8'(mul_pm(base, sng_pkg::PM_FULL - att[10:0]));
        end else begin
            next_turn_scale = 8'h00;
        end

        // Creep torque only while the motor is slow
        next_min_torque = motor_slow ? 8'(sat_level(min_torque_level) * sng_pkg::TORQUE_STEP) : 8'h00;

        // Coarse and fine levels merge; gain held off in open loop
        next_position_gain_active = closed;
        next_position_gain = closed
            ? 8'(sat_level(position_gain_coarse) * sng_pkg::FINE_PER_COARSE + sat_level(position_gain_fine))
            : 8'h00;

        // Error magnitude against the last steady position
        diff = 12'(commanded_pos - steady_pos);
        next_steering_error = diff[11] ? 12'(-diff) : diff;

        // Speed clamp: floor below 40 %, linear up to the angle, free above
        full = {16'h0, saturation_frequency} + {16'h0, extra_frequency_headroom};
        lo   = mul_pm({21'h0, err_ang}, sng_pkg::ERR_LOW_PM);
        if (!closed || {20'h0, next_steering_error} >= {21'h0, err_ang}) begin
            pm = {21'h0, sng_pkg::PM_FULL};
        end else if ({20'h0, next_steering_error} <= lo) begin
            pm = {21'h0, floor_pm};
        end else begin
            pm = {21'h0, floor_pm}
               + ({21'h0, sng_pkg::PM_FULL - floor_pm} * ({20'h0, next_steering_error} - lo))
                 / ({21'h0, err_ang} - lo);
        end
        next_motor_freq_limit = 17'(mul_pm(full, pm[10:0]));

        // Hand-set routing; local codes 2 and 3 reach neither processor
        next_handset_node     = remote_node_select;
        next_handset_to_main  = (local_processor_select == sng_pkg::LOCAL_MAIN);
        next_handset_to_slave = (local_processor_select == sng_pkg::LOCAL_SLAVE);

        // Request kind deliberately unused; only the encoder build centers
        next_centering_enable = encoder_toggle_feedback && centering_option
                                && (auto_request_kind == auto_request_kind);
    end

    // ************************************************************
    // Output registers
    // ************************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            max_angle            <= sng_pkg::ABS_MAX_ANGLE;
            turn_scale           <= 8'h00;
            min_torque           <= 8'h00;
            position_gain        <= 8'h00;
            position_gain_active <= 1'b0;
            steering_error       <= 12'h000;
            motor_freq_limit     <= 17'h00000;
            handset_node         <= 8'h00;
            handset_to_main      <= 1'b1;
            handset_to_slave     <= 1'b0;
            centering_enable     <= 1'b0;
        end else begin
            max_angle            <= next_max_angle;
            turn_scale           <= next_turn_scale;
            min_torque           <= next_min_torque;
            position_gain        <= next_position_gain;
            position_gain_active <= next_position_gain_active;
            steering_error       <= next_steering_error;
            motor_freq_limit     <= next_motor_freq_limit;
            handset_node         <= next_handset_node;
            handset_to_main      <= next_handset_to_main;
            handset_to_slave     <= next_handset_to_slave;
            centering_enable     <= next_centering_enable;
        end
    end

endmodule
